// >>> logic/idr_pkg.sv
//==============================================================
// constants and carriers of the diagnostic record
//==============================================================
// Overview of operation
// - channel type byte reads 70h, bit7 zero
// - diagnostic bits per channel reads 00h
// - channel count byte reads constant 02h
// - edge lost flags: bit0 channel0, bit1 channel1
// - timestamp holds ticker value at diagnostic event
// - 32-bit microsecond ticker, cleared at reset
// - ticker wraps to zero and keeps counting
// - outgoing diagnostic issued when cause disappears
// - first diagnostic byte bit3 flags channel error
// - fourth diagnostic byte bit6 flags lost interrupt
package idr_pkg;

  //==============================================================
  // timing
  //==============================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_CYCLES_RAW = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CYCLES = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
  localparam logic [6:0] PRESCALE_LAST = 7'(TICK_CYCLES - 1);
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  localparam logic [31:0] TICKER_RESET = 32'h00000000;

  //==============================================================
  // constant record contents
  //==============================================================
  localparam int unsigned NUM_CH = 2;
  localparam logic [7:0] CHAN_TYPE_DIGITAL_IN = 8'h70;
  localparam logic [7:0] DIAG_BITS_PER_CH = 8'h00;
  localparam logic [7:0] CHANNEL_COUNT = 8'h02;
  localparam logic [7:0] MODULE_INFO = 8'h1F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  //==============================================================
  // record byte indices
  //==============================================================
  localparam logic [4:0] IDX_DIAG_A = 5'h00;
  localparam logic [4:0] IDX_MOD_INFO = 5'h01;
  localparam logic [4:0] IDX_DIAG_C = 5'h02;
  localparam logic [4:0] IDX_DIAG_D = 5'h03;
  localparam logic [4:0] IDX_CHAN_TYPE = 5'h04;
  localparam logic [4:0] IDX_DIAG_BITS = 5'h05;
  localparam logic [4:0] IDX_CHAN_COUNT = 5'h06;
  localparam logic [4:0] IDX_EDGE_LOST = 5'h07;
  localparam logic [4:0] IDX_SPARE_FIRST = 5'h08;
  localparam logic [4:0] IDX_SPARE_LAST = 5'h0F;
  localparam logic [4:0] IDX_STAMP_FIRST = 5'h10;
  localparam logic [4:0] IDX_STAMP_LAST = 5'h13;

  //==============================================================
  // field positions and reset values
  //==============================================================
  localparam int unsigned DIAG_A_CHAN_ERR_BIT = 3;
  localparam int unsigned DIAG_D_IRQ_LOST_BIT = 6;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic [7:0] REC_DATA_RESET = 8'h00;
  localparam logic [31:0] STAMP_RESET = 32'h00000000;

  // process interrupt record handed to the partner
  typedef struct packed {
    logic [1:0] edges;
    logic [1:0] state;
    logic [15:0] stamp;
  } idr_proc_irq_t;

  // diagnostic notifications, one-cycle pulses
  typedef struct packed {
    logic incoming;
    logic going;
  } idr_diag_note_t;

endpackage : idr_pkg

// >>> logic/idr_ticker.sv
`timescale 1ns/1ps
//==============================================================
// free-running microsecond ticker
//==============================================================
module idr_ticker (
  input wire logic ref_clk,
  input wire logic reset,
  output logic [31:0] ticks
);

  logic [6:0] pre_q;
  logic [6:0] pre_d;
  logic [31:0] ticks_q;
  logic [31:0] ticks_d;
  logic tick_now;

  // prescaler marks one cycle per microsecond
  assign tick_now = (pre_q == idr_pkg::PRESCALE_LAST);
  assign pre_d = tick_now ? idr_pkg::PRESCALE_RESET : pre_q + 7'h01;
  // natural 32-bit rollover gives the wrap with no compare
  assign ticks_d = tick_now ? ticks_q + 32'h00000001 : ticks_q;
  assign ticks = ticks_q;

  // counter cleared at reset, then counts microseconds
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_q <= idr_pkg::PRESCALE_RESET;
      ticks_q <= idr_pkg::TICKER_RESET;
    end else begin
      pre_q <= pre_d;
      ticks_q <= ticks_d;
    end
  end

endmodule : idr_ticker

// >>> logic/idr_diag_record.sv
`timescale 1ns/1ps
//==============================================================
// two-channel input diagnostics and record readout
//==============================================================
module idr_diag_record (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic input_channel_zero,
  input wire logic input_channel_one,
  input wire logic [1:0] rise_irq_en,
  input wire logic [1:0] fall_irq_en,
  input wire logic diag_irq_en,
  output logic [1:0] input_state,
  output logic proc_irq_valid,
  input wire logic proc_irq_ready,
  output idr_pkg::idr_proc_irq_t proc_irq,
  output idr_pkg::idr_diag_note_t diag_note,
  output logic diag_active,
  input wire logic diag_ack,
  input wire logic rec_rd,
  input wire logic [4:0] rec_idx,
  output logic rec_valid,
  output logic [7:0] rec_data
);

  //==============================================================
  // declarations
  //==============================================================
  logic [31:0] ticks;
  logic [1:0] pins;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] prev_q;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] events;
  logic any_event;
  logic irq_taken;
  logic irq_busy;
  logic [1:0] lost_ev;
  logic pend_q;
  logic pend_d;
  idr_pkg::idr_proc_irq_t irq_q;
  idr_pkg::idr_proc_irq_t irq_d;
  logic [1:0] edge_lost_q;
  logic [1:0] edge_lost_d;
  logic irq_lost_q;
  logic irq_lost_d;
  logic cause;
  logic go_in;
  logic go_out;
  logic active_q;
  logic active_d;
  logic [31:0] stamp_q;
  logic [31:0] stamp_d;
  idr_pkg::idr_diag_note_t note_q;
  idr_pkg::idr_diag_note_t note_d;
  logic [7:0] diag_a;
  logic [7:0] diag_d_byte;
  logic [7:0] chan_type;
  logic [7:0] edge_byte;
  logic [1:0] stamp_sel;
  logic [7:0] stamp_byte;
  logic in_spare;
  logic in_stamp;
  logic [7:0] rec_byte;
  logic [7:0] rec_data_q;
  logic rec_valid_q;

  //==============================================================
  // microsecond ticker
  //==============================================================
  idr_ticker u_ticker (
    .ref_clk(ref_clk),
    .reset(reset),
    .ticks(ticks)
  );

  //==============================================================
  // input synchronisers and edge detection
  //==============================================================
  assign pins = {input_channel_one, input_channel_zero};

  // two stages before any logic looks at the pins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_q <= idr_pkg::FLAGS_RESET;
      sync2_q <= idr_pkg::FLAGS_RESET;
      prev_q <= idr_pkg::FLAGS_RESET;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // only enabled edges raise a process interrupt
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign events = (rise & rise_irq_en) | (fall & fall_irq_en);
  assign any_event = |events;
  assign input_state = prev_q;

  //==============================================================
  // process interrupt holding stage
  //==============================================================
  // one record deep: an edge arriving while the last one is unclaimed
  // cannot be stored, which is exactly the lost-edge case
  assign irq_taken = pend_q & proc_irq_ready;
  assign irq_busy = pend_q & ~proc_irq_ready;
  assign lost_ev = events & {2{irq_busy}};
  assign pend_d = (any_event & ~irq_busy) | irq_busy;
  assign irq_d = (any_event & ~irq_busy) ?
      idr_pkg::idr_proc_irq_t'{edges: events, state: sync2_q, stamp: ticks[15:0]} : irq_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_q <= 1'b0;
      irq_q <= '0;
    end else begin
      pend_q <= pend_d;
      irq_q <= irq_d;
    end
  end

  assign proc_irq_valid = pend_q;
  assign proc_irq = irq_q;

  //==============================================================
  // error flags
  //==============================================================
  // a new loss in the acknowledge cycle survives the clear
  assign edge_lost_d = (edge_lost_q & ~{2{diag_ack}}) | lost_ev;
  assign irq_lost_d = (irq_lost_q & ~diag_ack) | (|lost_ev);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      edge_lost_q <= idr_pkg::FLAGS_RESET;
      irq_lost_q <= 1'b0;
    end else begin
      edge_lost_q <= edge_lost_d;
      irq_lost_q <= irq_lost_d;
    end
  end

  //==============================================================
  // diagnostic incoming / going sequencing
  //==============================================================
  assign cause = (|edge_lost_q) | irq_lost_q;
  assign go_in = cause & ~active_q & diag_irq_en;
  // going needs no diag_irq_en, only the cause to vanish, which takes a diag_ack
  assign go_out = active_q & ~cause;
  assign active_d = go_in | (active_q & ~go_out);
  assign stamp_d = go_in ? ticks : stamp_q;
  assign note_d = '{incoming: go_in, going: go_out};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_q <= 1'b0;
      stamp_q <= idr_pkg::STAMP_RESET;
      note_q <= '0;
    end else begin
      active_q <= active_d;
      stamp_q <= stamp_d;
      note_q <= note_d;
    end
  end

  assign diag_note = note_q;
  assign diag_active = active_q;

  //==============================================================
  // record byte assembly
  //==============================================================
  // module-level channel error mirrors any lost edge
  // flag widened to a byte before the shift, so the bit cannot fall off a 1-bit operand
  assign diag_a = {7'h00, |edge_lost_q} << idr_pkg::DIAG_A_CHAN_ERR_BIT;
  assign diag_d_byte = {7'h00, irq_lost_q} << idr_pkg::DIAG_D_IRQ_LOST_BIT;
  assign chan_type = {1'b0, idr_pkg::CHAN_TYPE_DIGITAL_IN[6:0]};
  assign edge_byte = {6'h00, edge_lost_q};
  assign stamp_sel = rec_idx[1:0];
  assign stamp_byte = stamp_q[{stamp_sel, 3'h0} +: 8]; // least significant byte first
  assign in_spare = (rec_idx >= idr_pkg::IDX_SPARE_FIRST) &&
      (rec_idx <= idr_pkg::IDX_SPARE_LAST);
  assign in_stamp = (rec_idx >= idr_pkg::IDX_STAMP_FIRST) &&
      (rec_idx <= idr_pkg::IDX_STAMP_LAST);

  // unmapped indices and spare bytes return zero
  assign rec_byte =
      (rec_idx == idr_pkg::IDX_DIAG_A) ? diag_a :
      (rec_idx == idr_pkg::IDX_MOD_INFO) ? idr_pkg::MODULE_INFO :
      (rec_idx == idr_pkg::IDX_DIAG_C) ? idr_pkg::BYTE_ZERO :
      (rec_idx == idr_pkg::IDX_DIAG_D) ? diag_d_byte :
      (rec_idx == idr_pkg::IDX_CHAN_TYPE) ? chan_type :
      (rec_idx == idr_pkg::IDX_DIAG_BITS) ? idr_pkg::DIAG_BITS_PER_CH :
      (rec_idx == idr_pkg::IDX_CHAN_COUNT) ? idr_pkg::CHANNEL_COUNT :
      (rec_idx == idr_pkg::IDX_EDGE_LOST) ? edge_byte :
      in_spare ? idr_pkg::BYTE_ZERO :
      in_stamp ? stamp_byte :
      idr_pkg::BYTE_ZERO;

  // read data registered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rec_data_q <= idr_pkg::REC_DATA_RESET;
      rec_valid_q <= 1'b0;
    end else begin
      rec_data_q <= rec_rd ? rec_byte : rec_data_q;
      rec_valid_q <= rec_rd;
    end
  end

  assign rec_data = rec_data_q;
  assign rec_valid = rec_valid_q;

endmodule : idr_diag_record

// >>> test/idr_diag_record_checker.sv
`timescale 1ns/1ps
//==============================================================
// port checker of the diagnostic record
//==============================================================
module idr_diag_record_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rec_rd,
  input wire logic [4:0] rec_idx,
  input wire logic rec_valid,
  input wire logic [7:0] rec_data,
  input wire logic proc_irq_valid,
  input wire logic proc_irq_ready,
  input wire idr_pkg::idr_proc_irq_t proc_irq,
  input wire idr_pkg::idr_diag_note_t diag_note,
  input wire logic diag_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // one read strobe of a given byte
  sequence rd_s(logic [4:0] i);
    rec_rd && rec_idx == i;
  endsequence
  // incoming notice raises the fault level in the same cycle
  sequence note_in_s;
    diag_note.incoming && diag_active;
  endsequence

  rd_answer_a: assert property (rec_rd |=> rec_valid)
    else $error("read strobe not answered");
  rd_quiet_a: assert property (!rec_rd |=> !rec_valid)
    else $error("answer without read strobe");
  type_byte_a: assert property (
    rd_s(5'h04) |=> rec_data == 8'h70) else $error("channel type byte wrong");
  bit_count_a: assert property (
    rd_s(5'h05) |=> rec_data == 8'h00) else $error("diag bit count wrong");
  chan_count_a: assert property (
    rd_s(5'h06) |=> rec_data == 8'h02) else $error("channel count wrong");
  lost_reserved_a: assert property (
    rd_s(5'h07) |=> rec_data[7:2] == 6'h00) else $error("reserved flag bits set");
  spare_zero_a: assert property (
    rec_rd && rec_idx inside {[5'h08:5'h0F]} |=> rec_data == 8'h00)
    else $error("spare byte not zero");
  incoming_a: assert property (
    diag_note.incoming |-> note_in_s ##1 !diag_note.incoming)
    else $error("incoming notice malformed");
  going_a: assert property (
    diag_note.going |-> !diag_active && $past(diag_active))
    else $error("going notice without fault end");
  irq_hold_a: assert property (
    proc_irq_valid && !proc_irq_ready |=> proc_irq_valid && $stable(proc_irq))
    else $error("pending record changed");
endmodule : idr_diag_record_checker

bind idr_diag_record idr_diag_record_checker idr_diag_record_checker_inst (
  .ref_clk, .reset, .rec_rd, .rec_idx, .rec_valid, .rec_data, .proc_irq_valid,
  .proc_irq_ready, .proc_irq, .diag_note, .diag_active
);

// >>> test/idr_host_model.sv
`timescale 1ns/1ps
//==============================================================
// coupler side: takes process records, may stall
//==============================================================
module idr_host_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic proc_irq_valid,
  input wire idr_pkg::idr_proc_irq_t proc_irq,
  output logic proc_irq_ready,
  output idr_pkg::idr_proc_irq_t got
);
  // ready follows stall one edge late, as a busy coupler would
  always_ff @(posedge ref_clk) begin
    proc_irq_ready <= !reset && !stall;
    if (proc_irq_valid && proc_irq_ready) begin
      got <= proc_irq;
    end
  end
endmodule : idr_host_model

// >>> test/idr_diag_record_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end
//==============================================================
// bench top
//==============================================================
module idr_diag_record_tb;
  logic ref_clk, reset, input_channel_zero, input_channel_one, diag_irq_en, diag_ack;
  logic rec_rd, rec_valid, stall, proc_irq_valid, proc_irq_ready, diag_active;
  logic [1:0] irq_en, input_state;
  logic [4:0] rec_idx;
  logic [7:0] rec_data, d;
  logic [31:0] seed, cyc, ts_exp, st, ts_irq;
  idr_pkg::idr_proc_irq_t proc_irq, got;
  idr_pkg::idr_diag_note_t diag_note;
  int fail_count, num_checks;

  idr_diag_record idr_diag_record_inst (.ref_clk, .reset, .input_channel_zero,
    .input_channel_one, .rise_irq_en(irq_en), .fall_irq_en(irq_en), .diag_irq_en,
    .input_state, .proc_irq_valid, .proc_irq_ready, .proc_irq, .diag_note,
    .diag_active, .diag_ack, .rec_rd, .rec_idx, .rec_valid, .rec_data);
  idr_host_model idr_host_model_inst (.ref_clk, .reset, .stall, .proc_irq_valid,
    .proc_irq, .proc_irq_ready, .got);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // record contents while no loss has happened
  function automatic logic [7:0] exp_rec(input logic [4:0] i);
    case (i)
      5'h01: return 8'h1F;
      5'h04: return 8'h70;
      5'h06: return 8'h02;
      default: return 8'h00;
    endcase
  endfunction : exp_rec

  task automatic rd(input logic [4:0] i);
    @(posedge ref_clk) rec_rd <= 1'b1;
    rec_idx <= i;
    @(posedge ref_clk) rec_rd <= 1'b0;
    #1 `CHK(rec_valid, 1'b1)
    d = rec_data;
  endtask : rd

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ticker estimate: the stamp should match cycles since release divided by TICK_CYCLES
  always @(posedge ref_clk) begin
    cyc <= reset ? 32'h0 : cyc + 32'h1;
    if (diag_note.incoming) ts_exp <= cyc / idr_pkg::TICK_CYCLES;
  end

  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h46676234;
    fail_count = 0;
    num_checks = 0;
    reset = 1'b1;
    {input_channel_zero, input_channel_one, diag_irq_en, diag_ack, rec_rd, stall} = 6'h00;
    irq_en = 2'h3;
    rec_idx = 5'h00;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    // every byte once, then random indices, unmapped ones included
    for (int i = 0; i < 72; i++) begin
      seed = xs(seed);
      rd(i < 32 ? 5'(i) : seed[4:0]);
      `CHK(d, exp_rec(rec_idx))
    end
    repeat (200) @(posedge ref_clk);
    // stalled coupler: second edge is lost; pass 1 has diag notices off
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk) stall <= 1'b1;
      diag_irq_en <= (p == 0);
      repeat (3) @(posedge ref_clk);
      input_channel_zero <= ~input_channel_zero;
      // ticker estimate at the pin change; the record stamp may be one tick later
      ts_irq = cyc / idr_pkg::TICK_CYCLES;
      seed = xs(seed);
      repeat (5 + seed[1:0]) @(posedge ref_clk);
      if (p == 0) input_channel_zero <= ~input_channel_zero;
      else input_channel_one <= ~input_channel_one;
      repeat (8) @(posedge ref_clk);
      #1 `CHK(diag_active, 1'(p == 0))
      `CHK(input_state, {input_channel_one, input_channel_zero})
      rd(5'h07);
      `CHK(d, 8'(1 << p))
      rd(5'h00);
      `CHK(d, 8'h08)
      rd(5'h03);
      `CHK(d, 8'h40)
      for (int k = 0; k < 4; k++) begin
        rd(5'h10 + 5'(k));
        st[8*k +: 8] = d;
      end
      if (p == 0) `CHK(st + 32'h1 - ts_exp <= 32'h2, 1'b1)
      @(posedge ref_clk) stall <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 `CHK({got.edges, got.state}, 4'h5)
      `CHK(16'(got.stamp - ts_irq[15:0]) <= 16'h1, 1'b1)
      @(posedge ref_clk) diag_ack <= 1'b1;
      @(posedge ref_clk) diag_ack <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 `CHK(diag_active, 1'b0)
      rd(5'h07);
      `CHK(d, 8'h00)
    end
    // edge enables off with a stalled coupler: a toggle must leave nothing pending
    @(posedge ref_clk) irq_en <= 2'h0;
    stall <= 1'b1;
    repeat (3) @(posedge ref_clk);
    input_channel_zero <= ~input_channel_zero;
    repeat (8) @(posedge ref_clk);
    #1 `CHK(proc_irq_valid, 1'b0)
    `CHK(input_state, {input_channel_one, input_channel_zero})
    tally_and_finish();
  end
endmodule : idr_diag_record_tb
